// File: hw/sinc3_decimation_filter.sv
// Third-order sinc decimation filter for a 1-bit modulator stream
`default_nettype none

module sinc3_decimation_filter
   import sinc3_pkg::*;
#(
   parameter int OVERSAMPLING_RATIO = OSR_DEFAULT
) (
   input  wire logic                    ref_clk,
   input  wire logic                    reset,
   input  wire logic                    clk_en,
   input  wire logic                    reset_active_low,
   input  wire logic                    modulator_clock_pin,
   input  wire logic                    modulator_bit_in,
   input  wire logic                    decimation_strobe,
   input  wire logic                    select_internal_strobe,
   input  wire logic                    result_ready,
   output logic      [DATA_WIDTH-1:0]   filter_result,
   output logic      [WORD16_WIDTH-1:0] filter_result_16,
   output logic                         result_valid,
   output logic                         result_space,
   output logic                         result_overrun,
   output logic      [DATA_WIDTH-1:0]   fast_result,
   output logic                         fast_result_valid,
   output logic                         result_settled
);

   function automatic logic rising(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction : rising

   // Reset release synchroniser, asserted at once
   logic rst_meta_n;
   logic rst_n_sync;

   // Pin synchronisers
   logic mod_clk_meta;
   logic mod_clk_sync;
   logic mod_clk_prev;
   logic bit_meta;
   logic bit_sync;
   logic strobe_meta;
   logic strobe_sync;
   logic strobe_prev;
   logic [2:0] prime_pipe;

   // Integrator section
   logic [DATA_WIDTH-1:0] input_accumulator;
   logic [DATA_WIDTH-1:0] second_integrator;
   logic [DATA_WIDTH-1:0] third_integrator;

   // Differentiator delay line
   logic [DATA_WIDTH-1:0] integrator_capture;
   logic [DATA_WIDTH-1:0] previous_capture;
   logic [DATA_WIDTH-1:0] first_difference_delay;
   logic [DATA_WIDTH-1:0] second_difference_delay;

   // Fast second-order path
   logic [DATA_WIDTH-1:0] fast_capture;
   logic [DATA_WIDTH-1:0] fast_previous;
   logic [DATA_WIDTH-1:0] fast_difference_delay;
   logic [DATA_WIDTH-1:0] fast_history_1;
   logic [DATA_WIDTH-1:0] fast_history_2;

   // Output handling
   logic          push_pending;
   settle_state_t settle_state;
   settle_state_t next_settle_state;

   wire                  reset_any;
   wire                  pins_primed;
   wire                  mod_tick;
   wire                  ext_strobe;
   wire                  int_strobe;
   wire                  strobe_sel;
   wire                  step_integrators;
   wire                  step_delays;
   wire                  buf_in_ready;
   wire [DATA_WIDTH-1:0] first_difference;
   wire [DATA_WIDTH-1:0] second_difference;
   wire [DATA_WIDTH-1:0] third_difference;
   wire [DATA_WIDTH-1:0] fast_first_difference;
   wire [DATA_WIDTH-1:0] fast_sinc2;
   wire [DATA_WIDTH-1:0] next_input_accumulator;
   wire [DATA_WIDTH-1:0] next_second_integrator;
   wire [DATA_WIDTH-1:0] next_third_integrator;
   wire [DATA_WIDTH-1:0] next_fast_result;
   wire [DATA_WIDTH-1:0] buf_out_data;

   always_ff @(posedge ref_clk or negedge reset_active_low) begin
      if (!reset_active_low) begin
         rst_meta_n <= 1'b0;
         rst_n_sync <= 1'b0;
      end else if (clk_en) begin
         rst_meta_n <= 1'b1;
         rst_n_sync <= rst_meta_n;
      end
   end

   assign reset_any = reset | ~rst_n_sync;

   // Pins sampled directly, two flops each
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mod_clk_meta <= 1'b0;
         mod_clk_sync <= 1'b0;
         mod_clk_prev <= 1'b0;
         bit_meta     <= 1'b0;
         bit_sync     <= 1'b0;
      end else if (clk_en) begin
         mod_clk_meta <= modulator_clock_pin;
         mod_clk_sync <= mod_clk_meta;
         mod_clk_prev <= mod_clk_sync;
         bit_meta     <= modulator_bit_in;
         bit_sync     <= bit_meta;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         strobe_meta <= 1'b0;
         strobe_sync <= 1'b0;
         strobe_prev <= 1'b0;
      end else if (clk_en) begin
         strobe_meta <= decimation_strobe;
         strobe_sync <= strobe_meta;
         strobe_prev <= strobe_sync;
      end
   end

   // Edges ignored until prev holds a real pin value after reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prime_pipe <= 3'h0;
      end else if (clk_en) begin
         prime_pipe <= {prime_pipe[1:0], 1'b1};
      end
   end

   assign pins_primed = prime_pipe[2];

   // Rising modulator edge; bit delayed equally, stable since fall
   assign mod_tick   = pins_primed
                       & rising(mod_clk_sync, mod_clk_prev);
   assign ext_strobe = pins_primed
                       & rising(strobe_sync, strobe_prev);

   decimation_counter #(
      .RATIO (OVERSAMPLING_RATIO),
      .WIDTH (COUNT_WIDTH)
   ) u_counter (
      .ref_clk (ref_clk),
      .reset   (reset_any),
      .clk_en  (clk_en),
      .tick    (mod_tick),
      .strobe  (int_strobe)
   );

   // Word rate is modulator rate over the ratio
   assign strobe_sel = select_internal_strobe ? int_strobe
                                              : ext_strobe;

   assign step_integrators = clk_en & mod_tick & ~reset;
   assign step_delays      = clk_en & strobe_sel & ~reset;

   // Ones density 50 percent at zero input, 89.06 at full scale
   assign next_input_accumulator = bit_sync ?
      DATA_WIDTH'(input_accumulator + ACC_STEP) : input_accumulator;
   assign next_second_integrator =
      DATA_WIDTH'(second_integrator + input_accumulator);
   assign next_third_integrator  =
      DATA_WIDTH'(third_integrator + second_integrator);

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         input_accumulator <= DATA_ZERO;
         second_integrator <= DATA_ZERO;
         third_integrator  <= DATA_ZERO;
      end else if (reset) begin
         input_accumulator <= DATA_ZERO;
         second_integrator <= DATA_ZERO;
         third_integrator  <= DATA_ZERO;
      end else if (step_integrators) begin
         input_accumulator <= next_input_accumulator;
         second_integrator <= next_second_integrator;
         third_integrator  <= next_third_integrator;
      end
   end

   // Three differentiators at word rate; wraps modulo 2^24
   assign first_difference  =
      DATA_WIDTH'(integrator_capture - previous_capture);
   assign second_difference =
      DATA_WIDTH'(first_difference - first_difference_delay);
   assign third_difference  =
      DATA_WIDTH'(second_difference - second_difference_delay);

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         integrator_capture      <= DATA_ZERO;
         previous_capture        <= DATA_ZERO;
         first_difference_delay  <= DATA_ZERO;
         second_difference_delay <= DATA_ZERO;
      end else if (reset) begin
         integrator_capture      <= DATA_ZERO;
         previous_capture        <= DATA_ZERO;
         first_difference_delay  <= DATA_ZERO;
         second_difference_delay <= DATA_ZERO;
      end else if (step_delays) begin
         integrator_capture      <= third_integrator;
         previous_capture        <= integrator_capture;
         first_difference_delay  <= first_difference;
         second_difference_delay <= second_difference;
      end
   end

   // Second-order sinc from the second integrator
   assign fast_first_difference =
      DATA_WIDTH'(fast_capture - fast_previous);
   assign fast_sinc2 =
      DATA_WIDTH'(fast_first_difference - fast_difference_delay);
   // Delay of twice the ratio equals two words back
   assign next_fast_result =
      DATA_WIDTH'(fast_sinc2 + fast_history_2);

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         fast_capture          <= DATA_ZERO;
         fast_previous         <= DATA_ZERO;
         fast_difference_delay <= DATA_ZERO;
      end else if (reset) begin
         fast_capture          <= DATA_ZERO;
         fast_previous         <= DATA_ZERO;
         fast_difference_delay <= DATA_ZERO;
      end else if (step_delays) begin
         fast_capture          <= second_integrator;
         fast_previous         <= fast_capture;
         fast_difference_delay <= fast_first_difference;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         fast_history_1    <= DATA_ZERO;
         fast_history_2    <= DATA_ZERO;
         fast_result       <= DATA_ZERO;
         fast_result_valid <= 1'b0;
      end else if (reset) begin
         fast_history_1    <= DATA_ZERO;
         fast_history_2    <= DATA_ZERO;
         fast_result       <= DATA_ZERO;
         fast_result_valid <= 1'b0;
      end else if (clk_en) begin
         fast_result_valid <= push_pending;
         if (push_pending) begin
            fast_history_1 <= fast_sinc2;
            fast_history_2 <= fast_history_1;
            fast_result    <= next_fast_result;
         end
      end
   end

   // Word handed on one cycle after capture
   always_ff @(posedge ref_clk) begin
      if (reset_any) begin
         push_pending   <= 1'b0;
         result_overrun <= 1'b0;
      end else if (clk_en) begin
         push_pending   <= strobe_sel;
         result_overrun <= push_pending & ~buf_in_ready;
      end
   end

   result_buffer #(
      .WIDTH (DATA_WIDTH),
      .DEPTH (BUFFER_DEPTH)
   ) u_buffer (
      .ref_clk   (ref_clk),
      .reset     (reset_any),
      .clk_en    (clk_en),
      .in_valid  (push_pending),
      .in_ready  (buf_in_ready),
      .in_data   (third_difference),
      .out_valid (result_valid),
      .out_ready (result_ready),
      .out_data  (buf_out_data)
   );

   assign filter_result    = buf_out_data;
   // Upper bits give the 16-bit word at ratio 256
   assign filter_result_16 =
      buf_out_data[DATA_WIDTH-1 -: WORD16_WIDTH];
   assign result_space     = buf_in_ready;

   // Settling: counts updates after reset
   always_comb begin
      next_settle_state = settle_state;
      case (settle_state)
         SETTLE_NONE: begin
            next_settle_state = SETTLE_ONE;
         end
         SETTLE_ONE: begin
            next_settle_state = SETTLE_TWO;
         end
         SETTLE_TWO: begin
            next_settle_state = SETTLE_DONE;
         end
         SETTLE_DONE: begin
            next_settle_state = SETTLE_DONE;
         end
         default: begin
            next_settle_state = SETTLE_NONE;
         end
      endcase
   end

   // Step delay half of settling for continuous input
   always_ff @(posedge ref_clk) begin
      if (reset_any) begin
         settle_state <= SETTLE_NONE;
      end else if (clk_en && push_pending) begin
         settle_state <= next_settle_state;
      end
   end

   assign result_settled = (settle_state == SETTLE_DONE);

endmodule : sinc3_decimation_filter

`default_nettype wire

// File: hw/sinc3_pkg.sv
// Shared constants and types for the third-order sinc decimation filter
`default_nettype none

package sinc3_pkg;

   localparam int DATA_WIDTH     = 24;
   localparam int WORD16_WIDTH   = 16;
   localparam int OSR_DEFAULT    = 256;
   localparam int OSR_MIN        = 16;
   localparam int OSR_MAX        = 256;
   localparam int COUNT_WIDTH    = $clog2(OSR_MAX);
   localparam int BUFFER_DEPTH   = 2;
   localparam int SETTLE_UPDATES = 3;
   localparam int FAST_DELAY     = 2;

   localparam logic [DATA_WIDTH-1:0] ACC_STEP  = 24'h000001;
   localparam logic [DATA_WIDTH-1:0] DATA_ZERO = 24'h000000;

   typedef enum logic [1:0] {
      SETTLE_NONE = 2'b00,
      SETTLE_ONE  = 2'b01,
      SETTLE_TWO  = 2'b10,
      SETTLE_DONE = 2'b11
   } settle_state_t;

endpackage : sinc3_pkg

`default_nettype wire

// File: hw/decimation_counter.sv
// Internal decimation strobe generator counting modulator clock edges
`default_nettype none

module decimation_counter
   import sinc3_pkg::*;
#(
   parameter int RATIO = OSR_DEFAULT,
   parameter int WIDTH = COUNT_WIDTH
) (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic clk_en,
   input  wire logic tick,
   output logic      strobe
);

   localparam logic [WIDTH-1:0] LAST = WIDTH'(RATIO - 1);
   localparam logic [WIDTH-1:0] ZERO = '0;

   logic [WIDTH-1:0] count;
   wire              at_last;
   wire [WIDTH-1:0]  next_count;

   assign at_last    = (count == LAST);
   assign next_count = at_last ? ZERO : WIDTH'(count + 1'b1);
   // One strobe every RATIO modulator edges
   assign strobe     = tick & at_last;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count <= ZERO;
      end else if (clk_en && tick) begin
         count <= next_count;
      end
   end

endmodule : decimation_counter

`default_nettype wire

// File: hw/result_buffer.sv
// Two-entry result buffer with valid and ready on both sides
`default_nettype none

module result_buffer
   import sinc3_pkg::*;
#(
   parameter int WIDTH = DATA_WIDTH,
   parameter int DEPTH = BUFFER_DEPTH
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             clk_en,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int PTR_WIDTH = $clog2(DEPTH);
   localparam logic [PTR_WIDTH:0] FULL = (PTR_WIDTH + 1)'(DEPTH);

   logic [WIDTH-1:0]     mem [0:DEPTH-1];
   logic [PTR_WIDTH-1:0] wr_ptr;
   logic [PTR_WIDTH-1:0] rd_ptr;
   logic [PTR_WIDTH:0]   fill;
   wire                  push;
   wire                  pop;

   assign in_ready  = (fill != FULL);
   assign out_valid = (fill != '0);
   assign push      = in_valid & in_ready & clk_en;
   assign pop       = out_valid & out_ready & clk_en;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Depth must be a power of two for pointer wrap
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end else begin
         if (push) begin
            wr_ptr <= PTR_WIDTH'(wr_ptr + 1'b1);
         end
         if (pop) begin
            rd_ptr <= PTR_WIDTH'(rd_ptr + 1'b1);
         end
         if (push && !pop) begin
            fill <= (PTR_WIDTH + 1)'(fill + 1'b1);
         end else if (pop && !push) begin
            fill <= (PTR_WIDTH + 1)'(fill - 1'b1);
         end
      end
   end

endmodule : result_buffer

`default_nettype wire

// File: tb/sinc3_filter_assertions.sv
// Port-level checker for the sinc3 decimation filter
`default_nettype none

module sinc3_filter_checker
   import sinc3_pkg::*;
#(
   parameter int OVERSAMPLING_RATIO = OSR_DEFAULT
) (
   input wire logic                    ref_clk,
   input wire logic                    reset,
   input wire logic                    clk_en,
   input wire logic                    reset_active_low,
   input wire logic                    result_ready,
   input wire logic [DATA_WIDTH-1:0]   filter_result,
   input wire logic [WORD16_WIDTH-1:0] filter_result_16,
   input wire logic                    result_valid,
   input wire logic                    result_space,
   input wire logic                    result_overrun,
   input wire logic [DATA_WIDTH-1:0]   fast_result,
   input wire logic                    fast_result_valid,
   input wire logic                    result_settled
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   chk_reset_flags: assert property ($fell(reset) |-> !result_valid
      && result_space && !result_overrun && !result_settled
      && !fast_result_valid && fast_result == DATA_ZERO)
      else $error("outputs not at reset values");
   chk_word_top: assert property (result_valid |->
      filter_result_16 == filter_result[23:8])
      else $error("short word is not the top of the result");
   chk_overrun_full: assert property (result_overrun |->
      $past(!result_space))
      else $error("word dropped while buffer had space");
   chk_overrun_pulse: assert property (result_overrun && clk_en |=>
      !result_overrun)
      else $error("overrun longer than one cycle");
   chk_stall_hold: assert property (result_valid && reset_active_low
      && !(result_ready && clk_en) |=> result_valid && $stable(filter_result))
      else $error("result lost during stall");
   chk_fast_spacing: assert property (fast_result_valid && clk_en |=>
      !fast_result_valid [*8])
      else $error("output words too close together");
   chk_fast_hold: assert property ($changed(fast_result)
      && reset_active_low |-> fast_result_valid)
      else $error("fast result changed without its strobe");
   chk_settle_hold: assert property (result_settled && reset_active_low
      ##1 reset_active_low |-> result_settled)
      else $error("settled flag dropped without reset");
   chk_empty_space: assert property (!result_valid |-> result_space)
      else $error("empty buffer reports full");
   chk_async_clear: assert property (!reset_active_low |->
      fast_result == DATA_ZERO && !fast_result_valid)
      else $error("async clear left the fast path running");
endmodule : sinc3_filter_checker

bind sinc3_decimation_filter sinc3_filter_checker #(
   .OVERSAMPLING_RATIO(OVERSAMPLING_RATIO)
) u_sinc3_filter_checker (
   .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
   .reset_active_low(reset_active_low), .result_ready(result_ready),
   .filter_result(filter_result), .filter_result_16(filter_result_16),
   .result_valid(result_valid), .result_space(result_space),
   .result_overrun(result_overrun), .fast_result(fast_result),
   .fast_result_valid(fast_result_valid), .result_settled(result_settled)
);

`default_nettype wire

// File: tb/modulator_model.sv
// Behavioural modulator: free clock, bit stream and decimation strobe
`default_nettype none

module modulator_model #(
   parameter int RATIO = 16
) (
   input  wire logic [1:0] pattern,
   output logic            mod_clk,
   output logic            mod_bit,
   output logic            mod_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   int count = 0;

   initial begin
      mod_clk = 1'b0;
      mod_bit = 1'b0;
      mod_strobe = 1'b0;
      #37;
      forever begin
         #300 mod_clk = ~mod_clk;
      end
   end

   // Bit and strobe move on the falling edge only
   always @(negedge mod_clk) begin
      count = (count + 1) % RATIO;
      mod_strobe <= (count < RATIO / 2);
      case (pattern)
         2'h1: mod_bit <= 1'b1;
         2'h2: mod_bit <= ~mod_bit;
         default: mod_bit <= 1'b0;
      endcase
   end
endmodule : modulator_model

`default_nettype wire

// File: tb/sinc3_decimation_filter_bench.sv
// Self-checking bench for the sinc3 decimation filter
`default_nettype none

module sinc3_decimation_filter_bench
   import sinc3_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RATIO = 16;
   localparam int DLY = 1;
   localparam int WORD_NS = RATIO * 600;
   logic                    ref_clk = 1'b0;
   logic                    reset = 1'b1;
   logic                    clk_en = 1'b1;
   logic                    reset_active_low = 1'b0;
   logic                    select_internal_strobe = 1'b1;
   logic                    result_ready = 1'b1;
   logic [1:0]              pattern = 2'h0;
   logic                    mod_clk, mod_bit, mod_strobe;
   logic [DATA_WIDTH-1:0]   filter_result, fast_result, word;
   logic [WORD16_WIDTH-1:0] filter_result_16;
   logic                    result_valid, result_space, result_overrun;
   logic                    fast_result_valid, result_settled;
   int                      n_errors = 0;
   int                      cmp_count = 0;

   always #50 ref_clk = ~ref_clk;

   modulator_model #(.RATIO(RATIO)) u_modulator_model (
      .pattern(pattern), .mod_clk(mod_clk), .mod_bit(mod_bit),
      .mod_strobe(mod_strobe));

   sinc3_decimation_filter #(.OVERSAMPLING_RATIO(RATIO))
   u_sinc3_decimation_filter (
      .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
      .reset_active_low(reset_active_low),
      .modulator_clock_pin(mod_clk), .modulator_bit_in(mod_bit),
      .decimation_strobe(mod_strobe),
      .select_internal_strobe(select_internal_strobe),
      .result_ready(result_ready), .filter_result(filter_result),
      .filter_result_16(filter_result_16), .result_valid(result_valid),
      .result_space(result_space), .result_overrun(result_overrun),
      .fast_result(fast_result), .fast_result_valid(fast_result_valid),
      .result_settled(result_settled));

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [DATA_WIDTH-1:0] got,
                      input logic [DATA_WIDTH-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #DLY;
   endtask : tick

   // Waits for the head word, bounded
   task automatic get_word(output logic [DATA_WIDTH-1:0] w);
      int i;
      i = 0;
      do begin
         tick(1);
         i++;
      end while (result_valid !== 1'b1 && i < 400);
      chk(i < 400, 1'b1);
      w = filter_result;
   endtask : get_word

   task automatic t_reset();
      chk(result_valid, 1'b0);
      chk(result_space, 1'b1);
      chk(fast_result, DATA_ZERO);
      repeat (2) get_word(word);
      tick(1);
      chk(result_settled, 1'b0);
      get_word(word);
      tick(1);
      chk(result_settled, 1'b1);
      $display("t_reset done");
   endtask : t_reset

   // Density d in halves: 0 none, 1 half, 2 all ones
   task automatic t_steady(input logic [1:0] p, input logic s, input int d);
      time t0;
      pattern = p;
      select_internal_strobe = s;
      repeat (5) get_word(word);
      t0 = $time;
      get_word(word);
      chk(word, RATIO ** 3 * d / 2);
      chk(filter_result_16, (RATIO ** 3 * d / 2) >> 8);
      chk(fast_result, RATIO ** 2 * d);
      chk(fast_result_valid, 1'b1);
      chk(24'($time - t0), 24'(WORD_NS));
      $display("t_steady done");
   endtask : t_steady

   task automatic t_step();
      pattern = 2'h1;
      get_word(word);
      chk(word == RATIO ** 3, 1'b0);
      repeat (3) get_word(word);
      chk(word, RATIO ** 3);
      $display("t_step done");
   endtask : t_step

   task automatic t_buffer();
      logic ov;
      ov = 1'b0;
      result_ready = 1'b0;
      for (int i = 0; i < 400 && ov !== 1'b1; i++) begin
         tick(1);
         ov = result_overrun;
      end
      chk(ov, 1'b1);
      chk(result_space, 1'b0);
      result_ready = 1'b1;
      chk(filter_result, RATIO ** 3);
      tick(1);
      chk(result_valid, 1'b1);
      chk(filter_result, RATIO ** 3);
      tick(1);
      chk(result_valid, 1'b0);
      $display("t_buffer done");
   endtask : t_buffer

   task automatic t_freeze();
      result_ready = 1'b0;
      get_word(word);
      clk_en = 1'b0;
      result_ready = 1'b1;
      tick(200);
      chk(result_valid, 1'b1);
      chk(filter_result, RATIO ** 3);
      clk_en = 1'b1;
      $display("t_freeze done");
   endtask : t_freeze

   task automatic t_async();
      reset_active_low = 1'b0;
      tick(3);
      chk(fast_result, DATA_ZERO);
      chk(result_valid, 1'b0);
      chk(result_settled, 1'b0);
      reset_active_low = 1'b1;
      repeat (2) get_word(word);
      tick(1);
      chk(result_settled, 1'b0);
      $display("t_async done");
   endtask : t_async

   initial begin
      tick(20);
      reset = 1'b0;
      reset_active_low = 1'b1;
      tick(3);
      t_reset();
      t_steady(2'h2, 1'b1, 1);
      t_steady(2'h1, 1'b0, 2);
      t_steady(2'h0, 1'b1, 0);
      t_step();
      t_buffer();
      t_freeze();
      t_async();
      t_steady(2'h1, 1'b1, 2);
      end_sim();
   end

   // Limit far beyond the expected run of about 3600 cycles
   initial begin
      #(20000 * 100);
      n_errors++;
      end_sim();
   end
endmodule : sinc3_decimation_filter_bench

`default_nettype wire
